/* File: logic/plr_pkg.sv */
/*
 power-loss restore policy package: policy codes, timing constants, carrier structs.
 assumes a 200 MHz controller clock.
*/
package plr_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned WATCH_SECONDS = 30;
  localparam longint unsigned WATCH_CYCLES =
    longint'(WATCH_SECONDS) * 64'd1000000 * longint'(CLK_MHZ);
  localparam int unsigned CNT_W = 33;

  // ************************************************************
  // policy codes and reset values
  // ************************************************************
  typedef enum logic [1:0] {
    PLR_TURN_ON    = 2'h0,
    PLR_REMAIN_OFF = 2'h1,
    PLR_LAST_STATE = 2'h2
  } plr_policy_t;

  localparam logic LAST_ON_RST = 1'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic standby_ok;
    logic wake_req;
    logic off_req;
    logic has_standby;
  } plr_sys_in_t;

  typedef struct packed {
    logic last_on;
    logic last_on_we;
  } plr_nv_t;

endpackage : plr_pkg

/* File: logic/plr_watch.sv */
/*
 standby watch timer: counts cycles of unbroken standby after a switch-off.
 assumes a synchronous active-high reset and synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module plr_watch #(
  parameter longint unsigned LIMIT = plr_pkg::WATCH_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_standby_ok,
  output logic      o_running,
  output logic      o_done,
  output logic      o_lost
);

  typedef struct packed {
    logic [plr_pkg::CNT_W-1:0] cnt;
    logic                      run;
    logic                      done;
    logic                      lost;
  } plr_watch_st_t;

  plr_watch_st_t st;
  plr_watch_st_t next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    next_st.lost = 1'b0;
    if (i_start) begin
      next_st.run = 1'b1;
      next_st.cnt = '0;
    end else if (st.run) begin
      if (!i_standby_ok) begin
        next_st.run  = 1'b0;
        next_st.lost = 1'b1;
      end else if (st.cnt == plr_pkg::CNT_W'(LIMIT - 1)) begin
        next_st.run  = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_running = st.run;
  assign o_done    = st.done;
  assign o_lost    = st.lost;

endmodule : plr_watch
`default_nettype wire

/* File: logic/plr_top.sv */
/*
 power-loss restore policy of the board management controller.
 assumes synchronous inputs, reset held while standby is absent or carrier power is not good,
 and an external retained store for the last-state bit.
*/
// Function
// - after soft-off or total loss keep watching the standby rail
// - standby unbroken for 30 s after shutdown means orderly switch-off
// - standby lost inside the 30 s window means AC power loss
// - turn-on policy powers up automatically when standby returns
// - remain-off policy stays off until a wake request
// - last-state policy restores the stored on or off state
// - 30 s window used only under last-state policy
// - loss within 30 s of shutdown may leave last state wrongly on
// - without a standby rail the policy has no effect
// - main supply switched on by driving the active-low supply-on output
`timescale 1ns/1ps
`default_nettype none
module plr_top #(
  parameter longint unsigned WATCH_CYCLES = plr_pkg::WATCH_CYCLES
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_SYS_RST,
  input  wire logic                 I_CARRIER_POWER_GOOD,
  input  wire plr_pkg::plr_sys_in_t I_SYS,
  input  wire plr_pkg::plr_policy_t I_POLICY,
  input  wire logic                 I_NV_LAST_ON,
  output logic                      O_ATX_SUPPLY_ON_N,
  output plr_pkg::plr_nv_t          O_NV,
  output logic                      O_SYSTEM_ON,
  output logic                      O_AC_LOSS
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    ST_BOOT,
    ST_ON,
    ST_OFF
  } plr_mode_t;

  typedef struct packed {
    plr_mode_t        mode;
    logic             supply_on_n;
    plr_pkg::plr_nv_t nv;
    logic             ac_loss;
    logic             system_on;
  } plr_st_t;

  plr_st_t st;
  plr_st_t next_st;

  logic in_rst;
  logic watch_start;
  logic watch_run;
  logic watch_done;
  logic watch_lost;

  assign in_rst = I_SYS_RST | ~I_CARRIER_POWER_GOOD;

  // ************************************************************
  // standby watch
  // ************************************************************
  plr_watch #(
    .LIMIT (WATCH_CYCLES)
  ) u_watch (
    .i_clk        (I_CLK),
    .i_rst        (in_rst),
    .i_start      (watch_start),
    .i_standby_ok (I_SYS.standby_ok),
    .o_running    (watch_run),
    .o_done       (watch_done),
    .o_lost       (watch_lost)
  );

  // watch runs only under last-state after an orderly off
  assign watch_start = (st.mode == ST_ON) && I_SYS.off_req &&
                       (I_POLICY == plr_pkg::PLR_LAST_STATE);

  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb begin
    next_st               = st;
    next_st.nv.last_on_we = 1'b0;
    unique case (st.mode)
      ST_BOOT: begin
        if (!I_SYS.has_standby) begin
          next_st.mode = ST_OFF;
        end else begin
          unique case (I_POLICY)
            plr_pkg::PLR_TURN_ON:    next_st.mode = ST_ON;
            plr_pkg::PLR_REMAIN_OFF: next_st.mode = ST_OFF;
            plr_pkg::PLR_LAST_STATE: next_st.mode = I_NV_LAST_ON ? ST_ON : ST_OFF;
            default:                 next_st.mode = ST_OFF;
          endcase
        end
        if (next_st.mode == ST_ON) begin
          next_st.nv.last_on    = 1'b1;
          next_st.nv.last_on_we = 1'b1;
        end
      end
      ST_ON: begin
        if (I_SYS.off_req) begin
          next_st.mode          = ST_OFF;
          next_st.ac_loss       = 1'b0;
          // the stored bit stays on until the window closes: a loss inside it restores on
          if (I_POLICY != plr_pkg::PLR_LAST_STATE) begin
            next_st.nv.last_on    = 1'b0;
            next_st.nv.last_on_we = 1'b1;
          end
        end
      end
      ST_OFF: begin
        if (watch_done) begin
          next_st.nv.last_on    = 1'b0;
          next_st.nv.last_on_we = 1'b1;
        end
        if (watch_lost) begin
          next_st.ac_loss = 1'b1;
        end
        if (I_SYS.wake_req && !watch_run) begin
          next_st.mode          = ST_ON;
          next_st.nv.last_on    = 1'b1;
          next_st.nv.last_on_we = 1'b1;
        end
      end
      default: next_st.mode = ST_BOOT;
    endcase
    next_st.supply_on_n = (next_st.mode != ST_ON);
    next_st.system_on   = (next_st.mode == ST_ON);
  end

  always_ff @(posedge I_CLK) begin
    if (in_rst) begin
      st             <= '0;
      st.mode        <= ST_BOOT;
      st.supply_on_n <= 1'b1;
      st.nv.last_on  <= plr_pkg::LAST_ON_RST;
    end else begin
      st <= next_st;
    end
  end

  assign O_ATX_SUPPLY_ON_N = st.supply_on_n;
  assign O_NV              = st.nv;
  assign O_SYSTEM_ON       = st.system_on;
  assign O_AC_LOSS         = st.ac_loss;

  // ************************************************************
  // checks
  // ************************************************************
  a_supply_tracks_mode: assert property (@(posedge I_CLK) disable iff (in_rst)
    O_ATX_SUPPLY_ON_N == (st.mode != ST_ON)) else $error("supply-on level wrong");

  a_boot_turn_on: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_BOOT && I_SYS.has_standby && I_POLICY == plr_pkg::PLR_TURN_ON)
    |=> !O_ATX_SUPPLY_ON_N) else $error("turn-on policy did not power up");

  a_boot_remain_off: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_BOOT && I_POLICY == plr_pkg::PLR_REMAIN_OFF)
    |=> O_ATX_SUPPLY_ON_N) else $error("remain-off policy powered up");

  a_boot_last_state: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_BOOT && I_SYS.has_standby && I_POLICY == plr_pkg::PLR_LAST_STATE)
    |=> (O_ATX_SUPPLY_ON_N == !$past(I_NV_LAST_ON))) else $error("last state not restored");

  a_no_standby_off: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_BOOT && !I_SYS.has_standby) |=> O_ATX_SUPPLY_ON_N)
    else $error("policy acted without standby rail");

  a_watch_only_last: assert property (@(posedge I_CLK) disable iff (in_rst)
    (I_POLICY != plr_pkg::PLR_LAST_STATE && !watch_run) |=> !watch_run)
    else $error("watch started wrongly");

  a_loss_flagged: assert property (@(posedge I_CLK) disable iff (in_rst)
    (watch_run && !I_SYS.standby_ok && !watch_start) |=> ##1 O_AC_LOSS)
    else $error("standby loss not flagged");

  a_orderly_clears: assert property (@(posedge I_CLK) disable iff (in_rst)
    (watch_done && st.mode == ST_OFF && !I_SYS.wake_req) |=> !O_NV.last_on && O_NV.last_on_we)
    else $error("orderly off not recorded");

  a_on_recorded: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode != ST_ON && next_st.mode == ST_ON) |=> O_NV.last_on && O_NV.last_on_we)
    else $error("power-on not recorded");

  // ************************************************************
  // level and transition checks
  // ************************************************************
  a_on_level_pair: assert property (@(posedge I_CLK) disable iff (in_rst)
    O_SYSTEM_ON != O_ATX_SUPPLY_ON_N)
    else $error("system-on and supply-on disagree");

  a_wake_powers_up: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_OFF && I_SYS.wake_req && !watch_run) |=> !O_ATX_SUPPLY_ON_N)
    else $error("wake request did not power up");

  a_off_powers_down: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_ON && I_SYS.off_req) |=> O_ATX_SUPPLY_ON_N)
    else $error("off request did not power down");

  a_plain_off_stored: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_ON && I_SYS.off_req && I_POLICY != plr_pkg::PLR_LAST_STATE)
    |=> !O_NV.last_on && O_NV.last_on_we)
    else $error("power-off not recorded");

  a_last_off_deferred: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_ON && I_SYS.off_req && I_POLICY == plr_pkg::PLR_LAST_STATE)
    |=> !O_NV.last_on_we && watch_run)
    else $error("last-state off not deferred to window");

  a_loss_sticky: assert property (@(posedge I_CLK) disable iff (in_rst)
    (O_AC_LOSS && !(st.mode == ST_ON && I_SYS.off_req)) |=> O_AC_LOSS)
    else $error("loss flag dropped early");

  a_boot_one_cycle: assert property (@(posedge I_CLK) disable iff (in_rst)
    (st.mode == ST_BOOT) |=> (st.mode != ST_BOOT))
    else $error("restore decision not taken");

endmodule : plr_top
`default_nettype wire

/* File: sim/plr_atx_model.sv */
/*
 supply model: mains, standby rail, main outputs and the retained last-state store.
 assumes plr_top drives the supply-on output and the store write port.
*/
`timescale 1ns/1ps
`default_nettype none
module plr_atx_model (
  input  wire logic             i_clk,
  input  wire logic             i_ac_on,
  input  wire logic             i_supply_on_n,
  input  wire plr_pkg::plr_nv_t i_nv,
  output logic                  o_standby_ok,
  output logic                  o_main_on,
  output logic                  o_nv_last_on
);
  // ************************************************************
  // rails and retained store
  // ************************************************************
  assign o_standby_ok = i_ac_on;
  assign o_main_on    = i_ac_on & ~i_supply_on_n;
  initial o_nv_last_on = 1'h0;
  always @(posedge i_clk) begin
    if (i_nv.last_on_we) begin
      o_nv_last_on <= i_nv.last_on;
    end
  end
endmodule : plr_atx_model
`default_nettype wire

/* File: sim/tb.sv */
/*
 testbench for plr_top with a short watch window.
 assumes the supply model in plr_atx_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ************************************************************
  // stimulus and wiring
  // ************************************************************
  logic                 clk        = 1'h0;
  logic                 rst        = 1'h1;
  logic                 pg         = 1'h0;
  logic                 ac         = 1'h1;
  logic                 wake       = 1'h0;
  logic                 off        = 1'h0;
  logic                 hs         = 1'h1;
  plr_pkg::plr_policy_t pol        = plr_pkg::PLR_TURN_ON;
  int                   err_total  = 0;
  int                   num_checks = 0;
  logic                 son_n;
  logic                 sys_on;
  logic                 ac_loss;
  logic                 sb;
  logic                 main_on;
  logic                 nv_bit;
  plr_pkg::plr_nv_t     nv;
  plr_pkg::plr_sys_in_t sys_w;
  assign sys_w = {sb, wake, off, hs};
  always #2.5 clk = ~clk;

  plr_top #(.WATCH_CYCLES(20)) plr_top_inst (
    .I_CLK(clk), .I_SYS_RST(rst), .I_CARRIER_POWER_GOOD(pg), .I_SYS(sys_w),
    .I_POLICY(pol), .I_NV_LAST_ON(nv_bit), .O_ATX_SUPPLY_ON_N(son_n), .O_NV(nv),
    .O_SYSTEM_ON(sys_on), .O_AC_LOSS(ac_loss));
  plr_atx_model plr_atx_model_inst (
    .i_clk(clk), .i_ac_on(ac), .i_supply_on_n(son_n), .i_nv(nv),
    .o_standby_ok(sb), .o_main_on(main_on), .o_nv_last_on(nv_bit));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk
  task automatic boot(input plr_pkg::plr_policy_t p);
    @(negedge clk);
    pol = p;
    ac  = 1'h1;
    rst = 1'h1;
    pg  = 1'h0;
    cyc(6);
    rst = 1'h0;
    pg  = 1'h1;
    cyc(3);
  endtask : boot
  task automatic pulse_req(input logic is_off);
    if (is_off) off = 1'h1;
    else wake = 1'h1;
    cyc(1);
    off  = 1'h0;
    wake = 1'h0;
    cyc(3);
  endtask : pulse_req
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_turn_on();
    boot(plr_pkg::PLR_TURN_ON);
    chk("main_on", 1'h1, main_on);
    chk("supply_on_n", 1'h0, son_n);
    chk("nv_bit", 1'h1, nv_bit);
    pg = 1'h0;
    cyc(2);
    chk("system_on", 1'h0, sys_on);
    pg = 1'h1;
    $display("test turn_on done");
  endtask : t_turn_on
  task automatic t_remain_off();
    boot(plr_pkg::PLR_REMAIN_OFF);
    chk("system_on", 1'h0, sys_on);
    pulse_req(1'h0);
    chk("system_on", 1'h1, sys_on);
    pulse_req(1'h1);
    chk("nv_bit", 1'h0, nv_bit);
    ac = 1'h0;
    cyc(3);
    chk("ac_loss", 1'h0, ac_loss);
    $display("test remain_off done");
  endtask : t_remain_off
  task automatic t_orderly_off();
    pulse_req(1'h0);
    boot(plr_pkg::PLR_LAST_STATE);
    chk("system_on", 1'h1, sys_on);
    pulse_req(1'h1);
    chk("supply_on_n", 1'h1, son_n);
    chk("nv_bit", 1'h1, nv_bit);
    pulse_req(1'h0);
    chk("system_on", 1'h0, sys_on);
    cyc(12);
    chk("nv_bit", 1'h1, nv_bit);
    cyc(14);
    chk("nv_bit", 1'h0, nv_bit);
    chk("ac_loss", 1'h0, ac_loss);
    boot(plr_pkg::PLR_LAST_STATE);
    chk("system_on", 1'h0, sys_on);
    $display("test orderly_off done");
  endtask : t_orderly_off
  task automatic t_loss_in_window();
    pulse_req(1'h0);
    chk("nv_bit", 1'h1, nv_bit);
    pulse_req(1'h1);
    cyc(2);
    ac = 1'h0;
    cyc(3);
    chk("ac_loss", 1'h1, ac_loss);
    chk("nv_bit", 1'h1, nv_bit);
    boot(plr_pkg::PLR_LAST_STATE);
    chk("system_on", 1'h1, sys_on);
    $display("test loss_in_window done");
  endtask : t_loss_in_window
  task automatic t_no_standby();
    hs = 1'h0;
    boot(plr_pkg::PLR_TURN_ON);
    chk("system_on", 1'h0, sys_on);
    boot(plr_pkg::PLR_REMAIN_OFF);
    chk("system_on", 1'h0, sys_on);
    boot(plr_pkg::PLR_LAST_STATE);
    chk("system_on", 1'h0, sys_on);
    hs = 1'h1;
    boot(plr_pkg::plr_policy_t'(2'h3));
    chk("system_on", 1'h0, sys_on);
    $display("test no_standby done");
  endtask : t_no_standby

  initial begin
    t_turn_on();
    t_remain_off();
    t_orderly_off();
    t_loss_in_window();
    t_no_standby();
    tally_and_finish();
  end
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
